// ### hdl/otc_pkg.sv
// Package of constants and types for the oscillator trim and clock backup block.
package otc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ---------------------------------------------------------------
  localparam logic [11:0] OTC_ADDR_TRIM    = 12'h000;
  localparam logic [11:0] OTC_ADDR_CKCS    = 12'h004;
  localparam logic [11:0] OTC_ADDR_PROTECT = 12'h008;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OTC_CK_PORTC_HI  = 7;
  localparam int OTC_CK_PORTC_LO  = 6;
  localparam int OTC_CK_BACKUP    = 5;
  localparam int OTC_CK_SRC_SEL   = 4;
  localparam int OTC_CK_SW_IE     = 3;
  localparam int OTC_CK_SW_FLAG   = 2;
  localparam int OTC_CK_HALT      = 1;
  localparam int OTC_CK_STATUS    = 0;
  localparam int OTC_PR_WR_INH    = 7;
  localparam int OTC_PR_PROT_WE   = 6;
  localparam int OTC_PR_LOCK      = 5;
  localparam int OTC_PR_TRIM_WE   = 4;

  // ---------------------------------------------------------------
  // Values after reset, fixed read values and the trim sign mask
  // ---------------------------------------------------------------
  localparam logic [7:0] OTC_TRIM_RST     = 8'h00;
  localparam logic [7:0] OTC_TRIM_SIGN    = 8'h80;
  localparam logic [3:0] OTC_PR_LOW_READ  = 4'hf;
  localparam logic [7:0] OTC_CODE_NEUTRAL = 8'h80;

  // ---------------------------------------------------------------
  // Timing of the halt detector
  // ---------------------------------------------------------------
  localparam int OTC_CLK_MHZ      = 25;
  localparam int OTC_HALT_TIME_NS = 1000;
  localparam int OTC_HALT_CYCLES  = (OTC_HALT_TIME_NS * OTC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] OTC_HALT_CNT = 8'(OTC_HALT_CYCLES);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OTC_PORTC_IO     = 2'h0,
    OTC_PORTC_EXTCLK = 2'h1,
    OTC_PORTC_CLOCK_OUTPUT_PIN = 2'h2,
    OTC_PORTC_XTAL   = 2'h3
  } otc_portc_mode_t;

  typedef struct packed {
    logic pc1_io;
    logic pc1_clock_output_pin;
    logic pc1_xtal_out;
    logic pc0_io;
    logic pc0_clk_in;
  } otc_pin_role_t;

  typedef enum logic {
    OTC_ST_LOAD,
    OTC_ST_RUN
  } otc_state_t;

endpackage

// ### hdl/otc_halt_det.sv
// Detector that flags a stopped external oscillator from its sampled pin.
module otc_halt_det
  import otc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic enable,
  input  wire logic ext_osc_pin,
  // Result
  output logic      halted
);

  logic       sync1_ff, sync2_ff, prev_ff, halted_ff;
  logic [7:0] cnt_ff;
  logic       nxt_prev, nxt_halted;
  logic [7:0] nxt_cnt;

  // ---------------------------------------------------------------
  // Watchdog on pin edges
  // ---------------------------------------------------------------
  // Only the second synchroniser stage feeds the edge compare.
  always_comb begin
    nxt_prev   = sync2_ff;
    nxt_cnt    = cnt_ff;
    nxt_halted = halted_ff;
    if (!enable) begin
      nxt_cnt    = 8'h00;
      nxt_halted = 1'b0;
    end else if (sync2_ff != prev_ff) begin
      nxt_cnt    = 8'h00;
      nxt_halted = 1'b0;
    end else if (cnt_ff >= OTC_HALT_CNT) begin
      nxt_halted = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  // Registers of the detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff  <= 1'b0;
      sync2_ff  <= 1'b0;
      prev_ff   <= 1'b0;
      cnt_ff    <= 8'h00;
      halted_ff <= 1'b0;
    end else begin
      sync1_ff  <= ext_osc_pin;
      sync2_ff  <= sync1_ff;
      prev_ff   <= nxt_prev;
      cnt_ff    <= nxt_cnt;
      halted_ff <= nxt_halted;
    end
  end

  assign halted = halted_ff;

endmodule // otc_halt_det

// ### hdl/otc_top.sv
// Oscillator trim register, port C function select and clock backup control.
// Function
// - After reset, the trim register is loaded from the flash trim value.
// - Trim only steers the oscillator when the 20 MHz range is selected.
// - A trim write changes the oscillator code at once.
// - Trim is two's complement; code rises monotonically from 00h to FFh as trim goes 80h to 7Fh.
// - Bits 7:6 of clock control pick the port C pin roles.
// - Bit 5 enables halt detection and backup; resets to zero.
// - Halt while on external clock forces the on-chip oscillator.
// - Without backup, bit 4 directly selects the system clock source.
// - Switching from external to on-chip clock sets the switch flag.
// - Trim writes need lock-down clear and trim write enable set.
//
// The APB register port and the placing of the registers were decided locally.
module otc_top
  import otc_pkg::*;
(
  // APB slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Oscillator side
  input  wire logic [7:0]    flash_trim_data,
  input  wire logic          frequency_range_select,
  input  wire logic          ext_osc_pin,
  output logic [7:0]         osc_trim_code,
  output logic               system_clock_ext,
  output otc_pkg::otc_pin_role_t pin_role
);
  import otc_pkg::*;

  otc_state_t    state_ff, nxt_state;
  logic [7:0]    trim_ff, nxt_trim;
  logic [7:0]    code_ff, nxt_code;
  logic [1:0]    portc_ff, nxt_portc;
  logic          backup_ff, nxt_backup;
  logic          src_sel_ff, nxt_src_sel;
  logic          sw_ie_ff, nxt_sw_ie;
  logic          sw_flag_ff, nxt_sw_flag;
  logic          flag_seen_ff, nxt_flag_seen;
  logic          status_ff, nxt_status;
  logic          prot_we_ff, nxt_prot_we;
  logic          lock_ff, nxt_lock;
  logic          trim_we_ff, nxt_trim_we;
  logic          pready_ff, nxt_pready;
  logic          pslverr_ff, nxt_pslverr;
  logic [31:0]   prdata_ff, nxt_prdata;
  otc_pin_role_t role_ff, nxt_role;
  logic          halted;
  logic          wr_go, rd_go;
  logic          halt_read;

  // ---------------------------------------------------------------
  // Halt detector
  // ---------------------------------------------------------------
  otc_halt_det u_halt (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (backup_ff),
    .ext_osc_pin (ext_osc_pin),
    .halted      (halted)
  );

  // Pin roles from the port C field.
  function automatic otc_pin_role_t pin_decode(input logic [1:0] mode);
    otc_pin_role_t r;
    r = '0;
    case (otc_portc_mode_t'(mode))
      OTC_PORTC_IO: begin
        r.pc1_io = 1'b1;
        r.pc0_io = 1'b1;
      end
      OTC_PORTC_CLOCK_OUTPUT_PIN: begin
        r.pc1_clock_output_pin = 1'b1;
        r.pc0_io     = 1'b1;
      end
      OTC_PORTC_EXTCLK: begin
        r.pc0_clk_in = 1'b1;
      end
      default: begin
        r.pc1_xtal_out = 1'b1;
        r.pc0_clk_in   = 1'b1;
      end
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // A fixed one-wait-state answer keeps read data registered at pready.
  assign wr_go = psel && penable && pready_ff && pwrite;
  assign rd_go = psel && penable && pready_ff && !pwrite;
  // Halt bit reads one while detection is off, as the field is meaningless then.
  assign halt_read = backup_ff ? halted : 1'b1;

  // Next values of every register.
  always_comb begin
    nxt_state     = state_ff;
    nxt_trim      = trim_ff;
    nxt_portc     = portc_ff;
    nxt_backup    = backup_ff;
    nxt_src_sel   = src_sel_ff;
    nxt_sw_ie     = sw_ie_ff;
    nxt_sw_flag   = sw_flag_ff;
    nxt_flag_seen = flag_seen_ff;
    nxt_prot_we   = prot_we_ff;
    nxt_lock      = lock_ff;
    nxt_trim_we   = trim_we_ff;
    nxt_pready    = psel && penable && !pready_ff;
    nxt_pslverr   = 1'b0;
    nxt_prdata    = prdata_ff;
    case (state_ff)
      OTC_ST_LOAD: begin
        nxt_trim  = flash_trim_data;
        nxt_state = OTC_ST_RUN;
      end
      default: begin
        if (wr_go) begin
          if (paddr == OTC_ADDR_TRIM) begin
            if (!lock_ff && trim_we_ff) begin
              nxt_trim = pwdata[7:0];
            end
          end else if (paddr == OTC_ADDR_CKCS) begin
            nxt_portc  = pwdata[OTC_CK_PORTC_HI:OTC_CK_PORTC_LO];
            nxt_backup = pwdata[OTC_CK_BACKUP];
            nxt_sw_ie  = pwdata[OTC_CK_SW_IE];
            if (!pwdata[OTC_CK_SRC_SEL]) begin
              nxt_src_sel = 1'b0;
            end else if (!pwdata[OTC_CK_BACKUP] || !sw_flag_ff) begin
              nxt_src_sel = 1'b1;
            end
            // Flag clears only by writing zero after it was read as one.
            if (!pwdata[OTC_CK_SW_FLAG] && flag_seen_ff) begin
              nxt_sw_flag   = 1'b0;
              nxt_flag_seen = 1'b0;
            end
          end else if (paddr == OTC_ADDR_PROTECT) begin
            if (!pwdata[OTC_PR_WR_INH]) begin
              nxt_prot_we = pwdata[OTC_PR_PROT_WE];
              if (prot_we_ff) begin
                nxt_lock    = lock_ff | pwdata[OTC_PR_LOCK];
                nxt_trim_we = pwdata[OTC_PR_TRIM_WE];
              end
            end
          end
        end
        // Error answers are raised with pready only, never after the access ends.
        if (psel && penable && !pready_ff && !pwrite) begin
          if (paddr == OTC_ADDR_TRIM) begin
            nxt_prdata = {24'h000000, trim_ff};
          end else if (paddr == OTC_ADDR_CKCS) begin
            nxt_prdata = {24'h000000, portc_ff, backup_ff, src_sel_ff, sw_ie_ff,
                          sw_flag_ff, halt_read, status_ff};
          end else if (paddr == OTC_ADDR_PROTECT) begin
            nxt_prdata = {24'h000000, 1'b1, prot_we_ff, lock_ff, trim_we_ff,
                          OTC_PR_LOW_READ};
          end else begin
            nxt_prdata = 32'h00000000;
          end
        end
        if (psel && penable && !pready_ff && !pwrite && paddr != OTC_ADDR_TRIM
            && paddr != OTC_ADDR_CKCS && paddr != OTC_ADDR_PROTECT) begin
          nxt_pslverr = 1'b1;
        end
        if (psel && penable && !pready_ff && pwrite && paddr != OTC_ADDR_TRIM
            && paddr != OTC_ADDR_CKCS && paddr != OTC_ADDR_PROTECT) begin
          nxt_pslverr = 1'b1;
        end
        if (rd_go && paddr == OTC_ADDR_CKCS && sw_flag_ff) begin
          nxt_flag_seen = 1'b1;
        end
        // A halt drops the external selection whatever was written.
        if (backup_ff && halted && status_ff) begin
          nxt_src_sel = 1'b0;
        end
      end
    endcase
    nxt_status = nxt_src_sel;
    // Falling source is the switch event; it beats a clear in the same cycle.
    if (status_ff && !nxt_status) begin
      nxt_sw_flag = 1'b1;
    end
    // Sign bit flipped gives an offset code that rises from 00h up to FFh as trim goes 80h to 7Fh.
    nxt_code = frequency_range_select ? (nxt_trim ^ OTC_TRIM_SIGN)
                                      : OTC_CODE_NEUTRAL;
    nxt_role = pin_decode(nxt_portc);
  end

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= OTC_ST_LOAD;
      trim_ff      <= OTC_TRIM_RST;
      code_ff      <= OTC_CODE_NEUTRAL;
      portc_ff     <= 2'h0;
      backup_ff    <= 1'b0;
      src_sel_ff   <= 1'b0;
      sw_ie_ff     <= 1'b0;
      sw_flag_ff   <= 1'b0;
      flag_seen_ff <= 1'b0;
      status_ff    <= 1'b0;
      prot_we_ff   <= 1'b0;
      lock_ff      <= 1'b0;
      trim_we_ff   <= 1'b0;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      prdata_ff    <= 32'h00000000;
      role_ff      <= '0;
    end else begin
      state_ff     <= nxt_state;
      trim_ff      <= nxt_trim;
      code_ff      <= nxt_code;
      portc_ff     <= nxt_portc;
      backup_ff    <= nxt_backup;
      src_sel_ff   <= nxt_src_sel;
      sw_ie_ff     <= nxt_sw_ie;
      sw_flag_ff   <= nxt_sw_flag;
      flag_seen_ff <= nxt_flag_seen;
      status_ff    <= nxt_status;
      prot_we_ff   <= nxt_prot_we;
      lock_ff      <= nxt_lock;
      trim_we_ff   <= nxt_trim_we;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      prdata_ff    <= nxt_prdata;
      role_ff      <= nxt_role;
    end
  end

  assign pready           = pready_ff;
  assign prdata           = prdata_ff;
  assign pslverr          = pslverr_ff;
  assign osc_trim_code    = code_ff;
  assign system_clock_ext = status_ff;
  assign pin_role         = role_ff;

endmodule // otc_top

// ### bench/otc_top_asserts.sv
// Port checker for the oscillator trim and clock backup block.
module otc_top_asserts
  import otc_pkg::*;
(
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  // Oscillator side
  input wire logic [7:0]             flash_trim_data,
  input wire logic                   frequency_range_select,
  input wire logic                   ext_osc_pin,
  input wire logic [7:0]             osc_trim_code,
  input wire logic                   system_clock_ext,
  input wire otc_pkg::otc_pin_role_t pin_role
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic       pin_q_ff;
  logic       bak_ff;
  logic [5:0] quiet_ff;
  wire  done = psel && penable && pready && !pslverr;

  // Backup bit is shadowed from writes so the halt bound only runs while it is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q_ff <= 1'b0;
      bak_ff   <= 1'b0;
      quiet_ff <= 6'h00;
    end else begin
      pin_q_ff <= ext_osc_pin;
      if (done && pwrite && paddr == OTC_ADDR_CKCS) bak_ff <= pwdata[OTC_CK_BACKUP];
      if (ext_osc_pin != pin_q_ff || !system_clock_ext || !bak_ff) quiet_ff <= 6'h00;
      else if (quiet_ff != 6'h3f) quiet_ff <= quiet_ff + 6'h01;
    end
  end

  function automatic otc_pin_role_t role_of(input logic [1:0] m);
    case (m)
      2'h0:    return 5'h12;
      2'h1:    return 5'h01;
      2'h2:    return 5'h0a;
      default: return 5'h05;
    endcase
  endfunction

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_ck_rd;
    done && !pwrite && paddr == OTC_ADDR_CKCS;
  endsequence

  AST_READY_WAIT: assert property (s_wait |=> pready) else $error("no answer after access");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready held too long");
  AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_TRIM_NEUTRAL: assert property (!frequency_range_select && !$past(frequency_range_select)
    |-> osc_trim_code == 8'h80) else $error("trim applied outside range");
  AST_TRIM_CODE: assert property (done && !pwrite && paddr == OTC_ADDR_TRIM
    && frequency_range_select && $past(frequency_range_select)
    |-> osc_trim_code == (prdata[7:0] ^ 8'h80)) else $error("trim code mismatch");
  AST_PIN_ROLE: assert property (s_ck_rd |-> pin_role == role_of(prdata[7:6]))
    else $error("pin roles wrong");
  // Read data is latched at the same edge as pready, from the status held before that edge.
  AST_CLK_MIRROR: assert property (s_ck_rd |-> $past(system_clock_ext) == prdata[0])
    else $error("clock status mismatch");
  AST_OFF_HALT: assert property (s_ck_rd ##0 !prdata[5] |-> prdata[1])
    else $error("halt bit not one with backup off");
  AST_OFF_SRC: assert property (s_ck_rd ##0 !prdata[5] |-> prdata[0] == prdata[4])
    else $error("source not forced by select");
  AST_FORCE_SRC: assert property (done && pwrite && paddr == OTC_ADDR_CKCS
    && !pwdata[OTC_CK_BACKUP] |=> system_clock_ext == $past(pwdata[OTC_CK_SRC_SEL]))
    else $error("written source not applied");
  AST_HALT_SWITCH: assert property (quiet_ff <= 6'd40)
    else $error("no fallback after halt");
endmodule // otc_top_asserts

bind otc_top otc_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .flash_trim_data, .frequency_range_select, .ext_osc_pin,
  .osc_trim_code, .system_clock_ext, .pin_role);

// ### bench/otc_top_tb.sv
// Self-checking bench for the oscillator trim and clock backup block.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module otc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import otc_pkg::*;

  logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                   pwrite = 1'b0, pready, pslverr, rerr, osc_run = 1'b1;
  logic                   ext_osc_pin = 1'b0, frequency_range_select = 1'b1, system_clock_ext;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0, prdata, rdat;
  logic [7:0]             flash_trim_data = 8'h9c, osc_trim_code;
  otc_pin_role_t          pin_role;
  int                     bad_count = 0, checks = 0;

  otc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .flash_trim_data, .frequency_range_select, .ext_osc_pin,
    .osc_trim_code, .system_clock_ext, .pin_role);

  // Clock, and a running external oscillator that the halt tests can stop.
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (osc_run) ext_osc_pin <= ~ext_osc_pin;

  // One APB transfer; waits for pready without assuming the latency.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rdat, {24'h0, e})
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the sequence needs well under two thousand cycles.
  initial begin
    #(40 * 5000);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(OTC_ADDR_TRIM, 8'h9c);
    `CHK(osc_trim_code, 8'h1c)
    rd(OTC_ADDR_CKCS, 8'h02);
    rd(OTC_ADDR_PROTECT, 8'h8f);
    wr(OTC_ADDR_TRIM, 8'h33);
    rd(OTC_ADDR_TRIM, 8'h9c);
    wr(OTC_ADDR_PROTECT, 8'hc0);
    rd(OTC_ADDR_PROTECT, 8'h8f);
    wr(OTC_ADDR_PROTECT, 8'h40);
    wr(OTC_ADDR_PROTECT, 8'h50);
    rd(OTC_ADDR_PROTECT, 8'hdf);
    // Extremes and both sides of zero of the signed trim.
    for (int i = 0; i < 4; i++) begin
      logic [7:0] v;
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'h7f;
      wr(OTC_ADDR_TRIM, v);
      @(posedge pclk);
      `CHK(osc_trim_code, v ^ 8'h80)
      rd(OTC_ADDR_TRIM, v);
    end
    frequency_range_select <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(osc_trim_code, 8'h80)
    frequency_range_select <= 1'b1;
    wr(OTC_ADDR_PROTECT, 8'h70);
    wr(OTC_ADDR_TRIM, 8'h11);
    wr(OTC_ADDR_PROTECT, 8'h50);
    wr(OTC_ADDR_TRIM, 8'h22);
    rd(OTC_ADDR_TRIM, 8'h7f);
    xfer(1'b0, 12'h00c, 8'h00);
    `CHK({rerr, rdat}, 33'h100000000)
    xfer(1'b1, 12'h00c, 8'h55);
    `CHK(rerr, 1'b1)
    for (int m = 0; m < 4; m++) begin
      wr(OTC_ADDR_CKCS, {m[1:0], 6'h00});
      rd(OTC_ADDR_CKCS, {m[1:0], 6'h02});
    end
    wr(OTC_ADDR_CKCS, 8'h10);
    rd(OTC_ADDR_CKCS, 8'h13);
    `CHK(system_clock_ext, 1'b1)
    wr(OTC_ADDR_CKCS, 8'h00);
    rd(OTC_ADDR_CKCS, 8'h06);
    wr(OTC_ADDR_CKCS, 8'h00);
    rd(OTC_ADDR_CKCS, 8'h02);
    wr(OTC_ADDR_CKCS, 8'h20);
    repeat (40) @(posedge pclk);
    rd(OTC_ADDR_CKCS, 8'h20);
    wr(OTC_ADDR_CKCS, 8'h30);
    rd(OTC_ADDR_CKCS, 8'h31);
    osc_run <= 1'b0;
    repeat (60) @(posedge pclk);
    `CHK(system_clock_ext, 1'b0)
    rd(OTC_ADDR_CKCS, 8'h26);
    wr(OTC_ADDR_CKCS, 8'h34);
    rd(OTC_ADDR_CKCS, 8'h26);
    // A second reset must reload the trim from a new flash value and drop the lock.
    flash_trim_data <= 8'h5a;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(OTC_ADDR_TRIM, 8'h5a);
    `CHK(osc_trim_code, 8'hda)
    rd(OTC_ADDR_PROTECT, 8'h8f);
    rd(OTC_ADDR_CKCS, 8'h02);
    end_sim();
  end
endmodule // otc_top_tb
